// ==== inc/ceiu_consts.svh ====
`ifndef CEIU_CONSTS_SVH
`define CEIU_CONSTS_SVH

// ==========================================
// register offsets
`define CEIU_OFF_OVF_STICKY 8'h2a
`define CEIU_OFF_OVF_LIVE 8'h2b
`define CEIU_OFF_EVT_STICKY_A 8'h2c
`define CEIU_OFF_EVT_STICKY_B 8'h2d
`define CEIU_OFF_LIVE_A 8'h2e
`define CEIU_OFF_LIVE_B 8'h2f
`define CEIU_OFF_IRQ1_CTL 8'h30
`define CEIU_OFF_IRQ2_CTL 8'h31
`define CEIU_OFF_IRQ_STATUS 8'h38
`define CEIU_OFF_IRQ_MASK 8'h39

// ==========================================
// reset values
`define CEIU_RST_CTL 8'h00
`define CEIU_RST_MASK 8'h00
`define CEIU_RST_FLAGS 8'h00
`define CEIU_RD_UNMAPPED 8'h00

// ==========================================
// overflow flag bits
`define CEIU_B_DAC_OVF_L 7
`define CEIU_B_DAC_OVF_R 6
`define CEIU_B_ADC_OVF_L 3
`define CEIU_B_ADC_OVF_R 2

// ==========================================
// first live/sticky flag byte
`define CEIU_B_OC_L 7
`define CEIU_B_OC_R 6
`define CEIU_B_BUTTON 5
`define CEIU_B_HEADSET 4
`define CEIU_B_DRC_L 3
`define CEIU_B_DRC_R 2

// ==========================================
// second live/sticky flag byte
`define CEIU_B_NOISE_L 6
`define CEIU_B_NOISE_R 5
`define CEIU_B_DC_L 2
`define CEIU_B_DC_R 1

// ==========================================
// control, status and mask bits
`define CEIU_B_EN_INSERT 7
`define CEIU_B_EN_BUTTON 6
`define CEIU_B_EN_DRC 5
`define CEIU_B_EN_NOISE 4
`define CEIU_B_EN_OC 3
`define CEIU_B_EN_OVF 2
`define CEIU_B_EN_DC 1
`define CEIU_B_TRAIN 0

// ==========================================
// pulse timing
`define CEIU_PULSE_NS 2000000
`define CEIU_CLK_PERIOD_NS 4

`endif

// ==== inc/ceiu_pkg.sv ====
package ceiu_pkg;

    // ==========================================
    // carriers
    typedef struct packed {
        logic oc_left;
        logic oc_right;
        logic button;
        logic headset_in;
        logic drc_left;
        logic drc_right;
        logic noise_left;
        logic noise_right;
        logic dc_left;
        logic dc_right;
        logic dac_ovf_left;
        logic dac_ovf_right;
        logic adc_ovf_left;
        logic adc_ovf_right;
    } ceiu_events_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ceiu_bus_req_type;

    // ==========================================
    // pulse generator states
    typedef enum logic [2:0] {
        CEIU_IDLE = 3'b001,
        CEIU_HIGH = 3'b010,
        CEIU_LOW = 3'b100
    } ceiu_pulse_state_type;

endpackage : ceiu_pkg

// ==== hw/ceiu_sticky.sv ====
`timescale 1ns/1ns
module ceiu_sticky #(
    parameter int unsigned W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    import ceiu_pkg::*;

    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    if (W < 1) begin : g_bad_w
        $error("ceiu_sticky: W must be at least 1");
    end

    // a set in the clearing cycle survives
    assign q_d = (q_q & ~clr) | set;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule : ceiu_sticky

// ==== hw/ceiu_pulse_gen.sv ====
`timescale 1ns/1ns
module ceiu_pulse_gen #(
    parameter int unsigned PULSE_CYCLES = 500000,
    parameter int unsigned CNT_W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trig,
    input wire logic train,
    input wire logic stop,
    output logic pulse_out
);
    import ceiu_pkg::*;

    ceiu_pulse_state_type state_q;
    logic [CNT_W-1:0] cnt_q;
    logic last;

    if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_cnt
        $error("ceiu_pulse_gen: PULSE_CYCLES does not fit CNT_W");
    end

    assign last = (cnt_q == CNT_W'(PULSE_CYCLES - 1));

    // ==========================================
    // state
    // a new event restarts the pulse, even against a stop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= CEIU_IDLE;
        end else if (trig) begin
            state_q <= CEIU_HIGH;
        end else begin
            unique case (state_q)
                CEIU_IDLE: begin
                    state_q <= CEIU_IDLE;
                end
                CEIU_HIGH: begin
                    if (train && stop) begin
                        state_q <= CEIU_IDLE;
                    end else if (last) begin
                        state_q <= train ? CEIU_LOW : CEIU_IDLE;
                    end
                end
                CEIU_LOW: begin
                    if (stop || !train) begin
                        state_q <= CEIU_IDLE;
                    end else if (last) begin
                        state_q <= CEIU_HIGH;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // phase counter, high and low phases equal
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (trig || last || state_q == CEIU_IDLE) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    assign pulse_out = (state_q == CEIU_HIGH);
endmodule : ceiu_pulse_gen

// ==== hw/ceiu_top.sv ====
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`include "ceiu_consts.svh"
module ceiu_top #(
    parameter int unsigned PULSE_CYCLES = `CEIU_PULSE_NS / `CEIU_CLK_PERIOD_NS,
    parameter int unsigned CNT_W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ceiu_pkg::ceiu_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    input wire ceiu_pkg::ceiu_events_type events,
    output logic first_interrupt_output,
    output logic second_interrupt_output,
    output logic irq
);
    import ceiu_pkg::*;

    // ==========================================
    // elaboration checks
    if (PULSE_CYCLES < 1) begin : g_bad_pulse
        $error("ceiu_top: PULSE_CYCLES must be at least 1");
    end

    // ==========================================
    // functions
    function automatic logic [7:0] ceiu_ovf_byte(input ceiu_events_type e);
        logic [7:0] b;
        b = 8'h00;
        b[`CEIU_B_DAC_OVF_L] = e.dac_ovf_left;
        b[`CEIU_B_DAC_OVF_R] = e.dac_ovf_right;
        b[`CEIU_B_ADC_OVF_L] = e.adc_ovf_left;
        b[`CEIU_B_ADC_OVF_R] = e.adc_ovf_right;
        return b;
    endfunction : ceiu_ovf_byte

    function automatic logic [7:0] ceiu_byte_a(input ceiu_events_type e);
        logic [7:0] b;
        b = 8'h00;
        b[`CEIU_B_OC_L] = e.oc_left;
        b[`CEIU_B_OC_R] = e.oc_right;
        b[`CEIU_B_BUTTON] = e.button;
        b[`CEIU_B_HEADSET] = e.headset_in;
        b[`CEIU_B_DRC_L] = e.drc_left;
        b[`CEIU_B_DRC_R] = e.drc_right;
        return b;
    endfunction : ceiu_byte_a

    function automatic logic [7:0] ceiu_byte_b(input ceiu_events_type e);
        logic [7:0] b;
        b = 8'h00;
        b[`CEIU_B_NOISE_L] = e.noise_left;
        b[`CEIU_B_NOISE_R] = e.noise_right;
        b[`CEIU_B_DC_L] = e.dc_left;
        b[`CEIU_B_DC_R] = e.dc_right;
        return b;
    endfunction : ceiu_byte_b

    // groups event edges into the enable layout
    function automatic logic [7:0] ceiu_causes(input ceiu_events_type r);
        logic [7:0] c;
        c = 8'h00;
        c[`CEIU_B_EN_INSERT] = r.headset_in;
        c[`CEIU_B_EN_BUTTON] = r.button;
        c[`CEIU_B_EN_DRC] = r.drc_left | r.drc_right;
        c[`CEIU_B_EN_NOISE] = r.noise_left | r.noise_right;
        c[`CEIU_B_EN_OC] = r.oc_left | r.oc_right;
        c[`CEIU_B_EN_OVF] = r.dac_ovf_left | r.dac_ovf_right | r.adc_ovf_left | r.adc_ovf_right;
        c[`CEIU_B_EN_DC] = r.dc_left | r.dc_right;
        return c;
    endfunction : ceiu_causes

    // ==========================================
    // bus decode
    logic wr_ctl1;
    logic wr_ctl2;
    logic wr_mask;
    logic wr_status;
    logic rd_ovf_sticky;
    logic rd_sticky_a;
    logic rd_sticky_b;
    logic train_stop;

    assign wr_ctl1 = bus_req.wr && bus_req.addr == `CEIU_OFF_IRQ1_CTL;
    assign wr_ctl2 = bus_req.wr && bus_req.addr == `CEIU_OFF_IRQ2_CTL;
    assign wr_mask = bus_req.wr && bus_req.addr == `CEIU_OFF_IRQ_MASK;
    assign wr_status = bus_req.wr && bus_req.addr == `CEIU_OFF_IRQ_STATUS;
    assign rd_ovf_sticky = bus_req.rd && bus_req.addr == `CEIU_OFF_OVF_STICKY;
    assign rd_sticky_a = bus_req.rd && bus_req.addr == `CEIU_OFF_EVT_STICKY_A;
    assign rd_sticky_b = bus_req.rd && bus_req.addr == `CEIU_OFF_EVT_STICKY_B;

    // reading any sticky register ends a train
    assign train_stop = rd_ovf_sticky | rd_sticky_a | rd_sticky_b;

    // ==========================================
    // control registers
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic [7:0] mask_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl1_q <= `CEIU_RST_CTL;
        end else if (wr_ctl1) begin
            ctl1_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl2_q <= `CEIU_RST_CTL;
        end else if (wr_ctl2) begin
            ctl2_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_q <= `CEIU_RST_MASK;
        end else if (wr_mask) begin
            mask_q <= bus_req.wdata;
        end
    end

    // ==========================================
    // event edges
    ceiu_events_type prev_q;
    ceiu_events_type rise;
    logic headset_change;

    // previous sample cleared in reset, so an event already high at release counts as an edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= events;
        end
    end

    assign rise = events & ~prev_q;
    assign headset_change = events.headset_in ^ prev_q.headset_in;

    // ==========================================
    // sticky flags
    logic [23:0] sticky_set;
    logic [23:0] sticky_clr;
    logic [23:0] sticky_q;
    logic [7:0] sticky_a_set;

    always_comb begin
        sticky_a_set = ceiu_byte_a(events);
        sticky_a_set[`CEIU_B_HEADSET] = headset_change;
    end

    assign sticky_set = {ceiu_ovf_byte(events), sticky_a_set, ceiu_byte_b(events)};
    // read clears the read byte only
    assign sticky_clr = {{8{rd_ovf_sticky}}, {8{rd_sticky_a}}, {8{rd_sticky_b}}};

    ceiu_sticky #(
        .W(24)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set(sticky_set),
        .clr(sticky_clr),
        .q(sticky_q)
    );

    // ==========================================
    // interrupt routing
    logic [7:0] causes;
    logic trig1;
    logic trig2;

    assign causes = ceiu_causes(rise);

    assign trig1 = |(causes & ctl1_q & ~8'h01);
    assign trig2 = |(causes & ctl2_q & ~8'h01);

    // ==========================================
    // pulse generators
    // output one pulse form
    ceiu_pulse_gen #(
        .PULSE_CYCLES(PULSE_CYCLES),
        .CNT_W(CNT_W)
    ) u_pulse1 (
        .clk(clk),
        .rst_n(rst_n),
        .trig(trig1),
        .train(ctl1_q[`CEIU_B_TRAIN]),
        .stop(train_stop),
        .pulse_out(first_interrupt_output)
    );

    ceiu_pulse_gen #(
        .PULSE_CYCLES(PULSE_CYCLES),
        .CNT_W(CNT_W)
    ) u_pulse2 (
        .clk(clk),
        .rst_n(rst_n),
        .trig(trig2),
        .train(ctl2_q[`CEIU_B_TRAIN]),
        .stop(train_stop),
        .pulse_out(second_interrupt_output)
    );

    // ==========================================
    // software interrupt status
    logic [7:0] status_q;
    logic [7:0] status_clr;

    // write one to clear; bit 0 has no source
    assign status_clr = wr_status ? bus_req.wdata : 8'h00;

    ceiu_sticky #(
        .W(8)
    ) u_status (
        .clk(clk),
        .rst_n(rst_n),
        .set(causes),
        .clr(status_clr),
        .q(status_q)
    );

    assign irq = |(status_q & mask_q);

    // ==========================================
    // read data
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    // sticky bytes read their value before the clear lands
    always_comb begin
        rdata_d = `CEIU_RD_UNMAPPED;
        unique case (bus_req.addr)
            `CEIU_OFF_OVF_STICKY: rdata_d = sticky_q[23:16];
            `CEIU_OFF_OVF_LIVE: rdata_d = ceiu_ovf_byte(events);
            `CEIU_OFF_EVT_STICKY_A: rdata_d = sticky_q[15:8];
            `CEIU_OFF_EVT_STICKY_B: rdata_d = sticky_q[7:0];
            `CEIU_OFF_LIVE_A: rdata_d = ceiu_byte_a(events);
            `CEIU_OFF_LIVE_B: rdata_d = ceiu_byte_b(events);
            `CEIU_OFF_IRQ1_CTL: rdata_d = ctl1_q;
            `CEIU_OFF_IRQ2_CTL: rdata_d = ctl2_q;
            `CEIU_OFF_IRQ_STATUS: rdata_d = status_q;
            `CEIU_OFF_IRQ_MASK: rdata_d = mask_q;
            default: rdata_d = `CEIU_RD_UNMAPPED;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (bus_req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign bus_rdata = rdata_q;
endmodule : ceiu_top

// ==== verif/ceiu_top_properties.sv ====
`timescale 1ns/1ns
module ceiu_top_properties #(
    parameter int unsigned PULSE_CYCLES = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ceiu_pkg::ceiu_bus_req_type bus_req,
    input wire logic [7:0] bus_rdata,
    input wire ceiu_pkg::ceiu_events_type events,
    input wire logic first_interrupt_output,
    input wire logic second_interrupt_output,
    input wire logic irq
);
    import ceiu_pkg::*;
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic [7:0] mask_q;
    logic [31:0] run1_q;

    // ==========================================
    // shadow of the writable registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl1_q <= 8'h00;
            ctl2_q <= 8'h00;
            mask_q <= 8'h00;
        end else if (bus_req.wr) begin
            if (bus_req.addr == 8'h30) ctl1_q <= bus_req.wdata;
            if (bus_req.addr == 8'h31) ctl2_q <= bus_req.wdata;
            if (bus_req.addr == 8'h39) mask_q <= bus_req.wdata;
        end
    end

    // length of the current high phase of output one
    always_ff @(posedge clk) begin
        if (!rst_n || !first_interrupt_output) begin
            run1_q <= 32'h0;
        end else begin
            run1_q <= run1_q + 32'h1;
        end
    end

    // ==========================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RD_IDLE: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_LIVE_A: assert property (bus_req.rd && bus_req.addr == 8'h2e |=> bus_rdata ==
        {$past({events.oc_left, events.oc_right, events.button, events.headset_in,
        events.drc_left, events.drc_right}), 2'b00}) else $error("live byte a wrong");
    AST_LIVE_B: assert property (bus_req.rd && bus_req.addr == 8'h2f |=> bus_rdata ==
        {1'b0, $past({events.noise_left, events.noise_right}), 2'b00,
        $past({events.dc_left, events.dc_right}), 1'b0}) else $error("live byte b wrong");
    AST_BUTTON_OUT1: assert property ($rose(events.button) && ctl1_q[6] |=> first_interrupt_output)
        else $error("button did not raise output one");
    AST_INSERT_OUT2: assert property ($rose(events.headset_in) && ctl2_q[7] |=> second_interrupt_output)
        else $error("insertion did not raise output two");
    AST_QUIET: assert property (ctl1_q == 8'h00 && !first_interrupt_output |=> !first_interrupt_output)
        else $error("output one pulsed with all causes disabled");
    AST_WIDTH: assert property ($fell(first_interrupt_output) && !$past(bus_req.rd)
        |-> run1_q == PULSE_CYCLES) else $error("output one pulse width wrong");
    AST_TRAIN_STOP: assert property (bus_req.rd && bus_req.addr == 8'h2c && ctl1_q[0]
        && $stable(events) |=> !first_interrupt_output) else $error("train not stopped by read");
    AST_IRQ_MASKED: assert property (mask_q == 8'h00 |-> !irq)
        else $error("irq high with mask clear");
    AST_IRQ_SET: assert property ($rose(events.button) && mask_q[6] && !(bus_req.wr && bus_req.addr == 8'h39) |=> irq)
        else $error("irq not raised by unmasked event");

    cover property ($fell(first_interrupt_output));
    cover property ($rose(irq));
    cover property (bus_req.rd && bus_req.addr == 8'h2c && first_interrupt_output);
endmodule : ceiu_top_properties

bind ceiu_top ceiu_top_properties #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .events(events),
    .first_interrupt_output(first_interrupt_output),
    .second_interrupt_output(second_interrupt_output),
    .irq(irq)
);

// ==== verif/ceiu_host_model.sv ====
`timescale 1ns/1ns
module ceiu_host_model (
    input wire logic clk,
    input wire logic [7:0] bus_rdata,
    output ceiu_pkg::ceiu_bus_req_type bus_req
);
    import ceiu_pkg::*;
    initial begin
        bus_req = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // reading a sticky byte ends a train
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd
endmodule : ceiu_host_model

// ==== verif/ceiu_top_tb.sv ====
`timescale 1ns/1ns
module ceiu_top_tb;
    import ceiu_pkg::*;
    localparam int unsigned P = 8;
    logic clk;
    logic rst_n;
    ceiu_bus_req_type bus_req;
    logic [7:0] rdata;
    ceiu_events_type ev;
    ceiu_events_type e;
    logic out1;
    logic out2;
    logic irq;
    logic [7:0] d;
    int n;
    int num_errors;
    int n_checks;
    // event index for control bits 1..7
    int idx_of [8] = '{0, 5, 1, 12, 6, 9, 11, 10};
    logic [13:0] pats [3] = '{14'h3fff, 14'h2aaa, 14'h1555};

    ceiu_top #(.PULSE_CYCLES(P), .CNT_W(20)) i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .bus_req(bus_req),
        .bus_rdata(rdata),
        .events(ev),
        .first_interrupt_output(out1),
        .second_interrupt_output(out2),
        .irq(irq)
    );
    ceiu_host_model i_host (.clk(clk), .bus_rdata(rdata), .bus_req(bus_req));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        chk($sformatf("reg %h", a), d, exp);
    endtask : rchk

    task automatic clr();
        i_host.rd(8'h2a, d);
        i_host.rd(8'h2c, d);
        i_host.rd(8'h2d, d);
    endtask : clr

    // bounded so a stuck output cannot hang the run
    task automatic width(input logic lvl, output int cnt);
        cnt = 0;
        while (out1 === lvl && cnt < 40) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt == 40) begin
            num_errors++;
            finish_test();
        end
    endtask : width

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    // ==========================================
    // main sequence
    initial begin
        num_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        ev = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rchk(8'h30, 8'h00);
        rchk(8'h31, 8'h00);
        rchk(8'h40, 8'h00);
        i_host.wr(8'h30, 8'ha5);
        i_host.wr(8'h31, 8'h5a);
        i_host.wr(8'h2e, 8'hff);
        rchk(8'h30, 8'ha5);
        rchk(8'h31, 8'h5a);
        rchk(8'h2e, 8'h00);
        i_host.wr(8'h30, 8'h00);
        i_host.wr(8'h31, 8'h00);
        foreach (pats[i]) begin
            @(posedge clk);
            ev <= pats[i];
            e = pats[i];
            rchk(8'h2e, {e.oc_left, e.oc_right, e.button, e.headset_in, e.drc_left, e.drc_right, 2'b00});
            rchk(8'h2f, {1'b0, e.noise_left, e.noise_right, 2'b00, e.dc_left, e.dc_right, 1'b0});
            rchk(8'h2b, {e.dac_ovf_left, e.dac_ovf_right, 2'b00, e.adc_ovf_left, e.adc_ovf_right, 2'b00});
        end
        @(posedge clk);
        ev <= '0;
        clr();
        // every cause, enabled alone or all others enabled
        for (int ch = 0; ch < 2; ch++) begin
            for (int b = 1; b < 8; b++) begin
                for (int en = 0; en < 2; en++) begin
                    i_host.wr(8'(8'h30 + ch), en ? (8'h01 << b) : (~(8'h01 << b) & 8'hfe));
                    @(posedge clk);
                    ev[idx_of[b]] <= 1'b1;
                    @(posedge clk);
                    #1;
                    chk("outputs", {6'h00, out2, out1}, 8'(en << ch));
                    repeat (P + 2) @(posedge clk);
                    ev[idx_of[b]] <= 1'b0;
                    clr();
                    chk("after", {6'h00, out2, out1}, 8'h00);
                end
            end
            // leave this output disabled while the other one is swept
            i_host.wr(8'(8'h30 + ch), 8'h00);
        end
        @(posedge clk);
        ev.oc_left <= 1'b1;
        ev.dac_ovf_right <= 1'b1;
        ev.headset_in <= 1'b1;
        @(posedge clk);
        ev.oc_left <= 1'b0;
        ev.dac_ovf_right <= 1'b0;
        rchk(8'h2c, 8'h90);
        rchk(8'h2c, 8'h00);
        rchk(8'h2a, 8'h40);
        rchk(8'h2a, 8'h00);
        @(posedge clk);
        ev.headset_in <= 1'b0;
        rchk(8'h2c, 8'h10);
        i_host.wr(8'h30, 8'h41);
        i_host.wr(8'h31, 8'h41);
        @(posedge clk);
        ev.button <= 1'b1;
        @(posedge clk);
        #1;
        width(1'b1, n);
        chk("high", 8'(n), 8'(P));
        width(1'b0, n);
        chk("low", 8'(n), 8'(P));
        i_host.rd(8'h2c, d);
        chk("stop", {6'h00, out2, out1}, 8'h00);
        chk("sticky", d, 8'h20);
        n = 0;
        repeat (3 * P) begin
            @(posedge clk);
            #1;
            n += int'(out1 | out2);
        end
        chk("stopped", 8'(n), 8'h00);
        @(posedge clk);
        ev <= '0;
        clr();
        i_host.wr(8'h38, 8'hff);
        i_host.wr(8'h39, 8'h40);
        @(posedge clk);
        ev.button <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("irq", {7'h00, irq}, 8'h01);
        rchk(8'h38, 8'h40);
        i_host.wr(8'h38, 8'h40);
        @(posedge clk);
        #1;
        chk("irq", {7'h00, irq}, 8'h00);
        i_host.wr(8'h39, 8'h00);
        @(posedge clk);
        ev.drc_left <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("irq", {7'h00, irq}, 8'h00);
        rchk(8'h38, 8'h20);
        finish_test();
    end
endmodule : ceiu_top_tb
